// >>> cbcp_pkg.sv
// Constants and types shared by the coprocessor buffer command port.
// Assumes a byte-level link layer that has already done slot timing.
package cbcp_pkg;

   // Command codes.
   localparam logic [7:0] CMD_IPB_WRITE = 8'h0F;
   localparam logic [7:0] CMD_IPB_READ = 8'hAA;
   localparam logic [7:0] CMD_XIN_WRITE = 8'h2D;

   // Release sequence for the exchange buffer write, sent low byte first.
   localparam logic [15:0] CONF_XIN_WRITE = 16'h9DB3;

   // Product exchange buffer geometry.
   localparam int IPB_DEPTH = 128;
   localparam int IPB_AW = 7;
   localparam logic [7:0] IPB_LEN_MIN = 8'h01;
   localparam logic [7:0] IPB_LEN_MAX = 8'h80;

   // Exchange buffer input section.
   localparam logic [7:0] XIN_SIZE = 8'h08;
   localparam logic [3:0] XIN_FREE_RST = 4'h8;

   // Confirmation answers.
   localparam logic [7:0] ANS_ACCEPT = 8'h00;
   localparam logic [7:0] ANS_REJECT = 8'hFF;

   // CRC16, polynomial x^16+x^15+x^2+1 in reflected form, zero seed.
   localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
   localparam logic [15:0] CRC_SEED = 16'h0000;

   typedef enum logic [10:0] {
      ST_WAIT_ROM = 11'h001,
      ST_CMD = 11'h002,
      ST_LEN = 11'h004,
      ST_WDATA = 11'h008,
      ST_RDATA = 11'h010,
      ST_CRC_LO = 11'h020,
      ST_CRC_HI = 11'h040,
      ST_CONF_LO = 11'h080,
      ST_CONF_HI = 11'h100,
      ST_ANSWER = 11'h200,
      ST_DONE = 11'h400
   } cbcp_state_t;

   typedef struct packed {
      cbcp_state_t st;
      logic [7:0] cmd;
      logic [7:0] len;
      logic [7:0] cnt;
      logic [IPB_AW-1:0] ptr;
      logic [7:0] conf_lo;
      logic conf_ok;
      logic [63:0] xin;
      logic [3:0] xin_free;
      logic tx_valid;
      logic [7:0] tx_data;
      logic tx_msb_first;
      logic xin_notify;
      logic [3:0] xout_valid;
   } cbcp_port_t;

   typedef struct packed {
      logic [15:0] crc;
   } cbcp_crc_t;

endpackage : cbcp_pkg

// >>> cbcp_crc16.sv
// Running CRC16 accumulator, one byte per cycle.
// Assumes the caller says in which bit order the byte travels on the wire.
`timescale 1ns/1ps
module cbcp_crc16
   import cbcp_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Byte feed.
   input wire logic clear,
   input wire logic update,
   input wire logic [7:0] din,
   input wire logic msb_first,
   // Result.
   output logic [15:0] crc
);

   cbcp_crc_t s;
   cbcp_crc_t s_next;

   function automatic logic [15:0] cbcp_crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = r[0] ^ d[i];
         r = r >> 1;
         if (fb) begin
            r = r ^ CRC_POLY_REFL;
         end
      end
      return r;
   endfunction : cbcp_crc_byte

   function automatic logic [7:0] cbcp_rev8(input logic [7:0] d);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = d[7-i];
      end
      return r;
   endfunction : cbcp_rev8

   // Bits enter in the order they cross the wire, so a byte sent MSB first is reversed.
   always_comb begin
      s_next = s;
      if (clear) begin
         s_next.crc = CRC_SEED;
      end else if (update) begin
         s_next.crc = cbcp_crc_byte(s.crc, msb_first ? cbcp_rev8(din) : din);
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s <= '{crc: CRC_SEED};
      end else begin
         s <= s_next;
      end
   end

   assign crc = s.crc;

endmodule : cbcp_crc16

// >>> cbcp_ipb_mem.sv
// Storage for the 128-byte circular product exchange buffer.
// Assumes one write and one registered read per cycle.
`timescale 1ns/1ps
module cbcp_ipb_mem
   import cbcp_pkg::*;
(
   // Clock.
   input wire logic core_clk,
   // Write port.
   input wire logic we,
   input wire logic [IPB_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // Read port.
   input wire logic [IPB_AW-1:0] raddr,
   output logic [7:0] rdata_reg
);

   logic [7:0] mem_reg [IPB_DEPTH];

   // The array has no reset, so its contents are undefined until first written.
   always_ff @(posedge core_clk) begin
      if (we) begin
         mem_reg[waddr] <= wdata;
      end
      rdata_reg <= mem_reg[raddr];
   end

endmodule : cbcp_ipb_mem

// >>> cbcp_cmd_port.sv
// Command interpreter for the coprocessor buffers behind the single-wire bus.
// Assumes a link layer on core_clk that hands over whole bytes, flags the
// end of addressing and bus reset pulses, and asks for each byte it reads.
`timescale 1ns/1ps
module cbcp_cmd_port
   import cbcp_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Link layer events.
   input wire logic rom_done,
   input wire logic bus_reset,
   // Received bytes, first received bit in bit 0.
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   // Byte read slots from the master.
   input wire logic tx_req,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_msb_first,
   // Microcomputer side.
   input wire logic ipb_processed,
   input wire logic xin_take,
   input wire logic [3:0] xout_count,
   output logic [63:0] xin_data,
   output logic [3:0] xin_free,
   output logic [3:0] xout_valid,
   output logic xin_notify
);

   cbcp_port_t s;
   cbcp_port_t s_next;

   logic crc_clr;
   logic crc_upd;
   logic [7:0] crc_din;
   logic crc_msb;
   logic [15:0] crc;
   logic mem_we;
   logic [IPB_AW-1:0] mem_waddr;
   logic [IPB_AW-1:0] mem_raddr;
   logic [7:0] mem_rdata;
   logic [3:0] free_base;
   logic last_byte;

   cbcp_crc16 u_crc (
      .core_clk(core_clk),
      .reset(reset),
      .clear(crc_clr),
      .update(crc_upd),
      .din(crc_din),
      .msb_first(crc_msb),
      .crc(crc)
   );

   cbcp_ipb_mem u_mem (
      .core_clk(core_clk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(rx_data),
      .raddr(mem_raddr),
      .rdata_reg(mem_rdata)
   );

   // Unprocessed data is read downward from the byte below the pointer, so the
   // read port tracks the next pointer and the byte is ready one cycle later.
   assign mem_raddr = ipb_processed ? s_next.ptr : IPB_AW'(s_next.ptr - 1'b1);
   assign last_byte = (8'(s.cnt + 8'h01) == s.len);

   always_comb begin
      s_next = s;
      s_next.tx_valid = 1'b0;
      s_next.tx_msb_first = 1'b0;
      s_next.xin_notify = 1'b0;
      crc_clr = 1'b0;
      crc_upd = 1'b0;
      crc_din = rx_data;
      crc_msb = 1'b0;
      mem_we = 1'b0;
      mem_waddr = s.ptr;
      // A drain by the microcomputer comes first so that an accept in the same
      // cycle still takes its bytes off the refreshed count.
      free_base = xin_take ? XIN_FREE_RST : s.xin_free;
      s_next.xin_free = free_base;
      // The valid output count belongs to the micro; it is only registered here,
      // so xout_valid follows xout_count one cycle later and can change in any cycle.
      s_next.xout_valid = xout_count;
      if (bus_reset) begin
         s_next.st = ST_WAIT_ROM;
      end else begin
         unique case (s.st)
            ST_WAIT_ROM: begin
               if (rom_done) begin
                  s_next.st = ST_CMD;
                  crc_clr = 1'b1;
               end
            end
            ST_CMD: begin
               if (rx_valid) begin
                  s_next.cmd = rx_data;
                  crc_upd = 1'b1;
                  if (rx_data == CMD_IPB_WRITE || rx_data == CMD_IPB_READ ||
                      rx_data == CMD_XIN_WRITE) begin
                     s_next.st = ST_LEN;
                  end else begin
                     s_next.st = ST_DONE;
                  end
               end
            end
            ST_LEN: begin
               // A refused length parks the interpreter like an unknown command;
               // only a bus reset brings it back.
               if (rx_valid) begin
                  s_next.len = rx_data;
                  s_next.cnt = 8'h00;
                  crc_upd = 1'b1;
                  s_next.st = ST_DONE;
                  if (s.cmd == CMD_IPB_WRITE) begin
                     if (rx_data >= IPB_LEN_MIN && rx_data <= IPB_LEN_MAX) begin
                        s_next.st = ST_WDATA;
                     end
                  end else if (s.cmd == CMD_IPB_READ) begin
                     if (rx_data <= IPB_LEN_MAX) begin
                        s_next.st = (rx_data == 8'h00) ? ST_CRC_LO : ST_RDATA;
                     end
                  end else if (rx_data <= XIN_SIZE) begin
                     s_next.st = (rx_data == 8'h00) ? ST_CRC_LO : ST_WDATA;
                  end
               end
            end
            ST_WDATA: begin
               if (rx_valid) begin
                  crc_upd = 1'b1;
                  s_next.cnt = 8'(s.cnt + 8'h01);
                  if (s.cmd == CMD_IPB_WRITE) begin
                     // Only the written locations change; the rest keeps old data.
                     mem_we = 1'b1;
                     s_next.ptr = IPB_AW'(s.ptr + 1'b1);
                  end else begin
                     s_next.xin[{s.cnt[2:0], 3'b000} +: 8] = rx_data;
                  end
                  if (last_byte) begin
                     s_next.st = ST_CRC_LO;
                  end
               end
            end
            ST_RDATA: begin
               if (tx_req) begin
                  s_next.tx_valid = 1'b1;
                  s_next.tx_data = mem_rdata;
                  s_next.tx_msb_first = !ipb_processed;
                  crc_upd = 1'b1;
                  crc_din = mem_rdata;
                  crc_msb = !ipb_processed;
                  // The pointer moves with every byte, so a second read of 128
                  // minus this length brings it back round; any other ending
                  // leaves the buffer rotated, though its stored bytes stay unchanged.
                  s_next.ptr = ipb_processed ? IPB_AW'(s.ptr + 1'b1)
                                             : IPB_AW'(s.ptr - 1'b1);
                  s_next.cnt = 8'(s.cnt + 8'h01);
                  if (last_byte) begin
                     s_next.st = ST_CRC_LO;
                  end
               end
            end
            ST_CRC_LO: begin
               if (tx_req) begin
                  s_next.tx_valid = 1'b1;
                  s_next.tx_data = ~crc[7:0];
                  s_next.st = ST_CRC_HI;
               end
            end
            ST_CRC_HI: begin
               if (tx_req) begin
                  s_next.tx_valid = 1'b1;
                  s_next.tx_data = ~crc[15:8];
                  s_next.st = (s.cmd == CMD_XIN_WRITE) ? ST_CONF_LO : ST_DONE;
               end
            end
            ST_CONF_LO: begin
               if (rx_valid) begin
                  s_next.conf_lo = rx_data;
                  s_next.st = ST_CONF_HI;
               end
            end
            ST_CONF_HI: begin
               // The free count is checked only here, as the length byte is held to XIN_SIZE
               // alone, so a drain by the micro since the length byte arrived still counts.
               if (rx_valid) begin
                  s_next.st = ST_ANSWER;
                  s_next.conf_ok = 1'b0;
                  if ({rx_data, s.conf_lo} == CONF_XIN_WRITE &&
                      s.len <= {4'h0, free_base}) begin
                     s_next.conf_ok = 1'b1;
                     s_next.xin_free = 4'(free_base - s.len[3:0]);
                     s_next.xin_notify = 1'b1;
                  end
               end
            end
            ST_ANSWER: begin
               if (tx_req) begin
                  s_next.tx_valid = 1'b1;
                  s_next.tx_data = s.conf_ok ? ANS_ACCEPT : ANS_REJECT;
                  s_next.st = ST_DONE;
               end
            end
            ST_DONE: begin
               s_next.st = ST_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s <= '{st: ST_WAIT_ROM, xin_free: XIN_FREE_RST, default: '0};
      end else begin
         s <= s_next;
      end
   end

   assign tx_valid = s.tx_valid;
   assign tx_data = s.tx_data;
   assign tx_msb_first = s.tx_msb_first;
   assign xin_data = s.xin;
   assign xin_free = s.xin_free;
   assign xout_valid = s.xout_valid;
   assign xin_notify = s.xin_notify;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   wait_rom_a: assert property ((s.st == ST_WAIT_ROM && !rom_done) |=> s.st == ST_WAIT_ROM)
      else $error("Left address wait without addressing.");
   abort_a: assert property (bus_reset |=> s.st == ST_WAIT_ROM && !tx_valid)
      else $error("Bus reset did not abort the command.");
   done_hold_a: assert property ((s.st == ST_DONE && !bus_reset) |=> s.st == ST_DONE)
      else $error("Interpreter left idle without bus reset.");
   answer_slot_a: assert property (tx_valid |-> $past(tx_req))
      else $error("Byte sent without a read slot.");
   crc_low_a: assert property ((s.st == ST_CRC_LO && tx_req && !bus_reset)
                               |=> tx_valid && tx_data == ~$past(crc[7:0]))
      else $error("Low CRC byte is not the inverted CRC.");
   crc_high_a: assert property ((s.st == ST_CRC_HI && tx_req && !bus_reset)
                                |=> tx_valid && tx_data == ~$past(crc[15:8]))
      else $error("High CRC byte is not the inverted CRC.");
   msb_order_a: assert property ((tx_valid && tx_msb_first) |-> !$past(ipb_processed))
      else $error("MSB first order used for processed data.");
   lsb_order_a: assert property ((s.st == ST_RDATA && tx_req && ipb_processed && !bus_reset)
                                 |=> tx_valid && !tx_msb_first)
      else $error("Processed data not sent LSB first.");
   confirm_a: assert property (xin_notify |-> $past(s.st == ST_CONF_HI && rx_valid)
                               && $past(rx_data) == CONF_XIN_WRITE[15:8])
      else $error("Notify without the release code.");
   reject_code_a: assert property ((s.st == ST_CONF_HI && rx_valid && !bus_reset &&
                                    {rx_data, s.conf_lo} != CONF_XIN_WRITE)
                                   |=> !xin_notify && !s.conf_ok)
      else $error("Wrong release code was accepted.");
   reply_a: assert property ((s.st == ST_ANSWER && tx_req && !bus_reset)
                             |=> tx_data == (s.conf_ok ? ANS_ACCEPT : ANS_REJECT))
      else $error("Confirmation answer wrong.");
   len_start_a: assert property ((s.st == ST_LEN && rx_valid && !bus_reset)
                                 |=> s.cnt == 8'h00)
      else $error("Transfer did not start at location zero.");
   len_range_a: assert property ((s.st == ST_LEN && rx_valid && !bus_reset &&
                                  s.cmd == CMD_IPB_WRITE &&
                                  (rx_data < IPB_LEN_MIN || rx_data > IPB_LEN_MAX))
                                 |=> s.st == ST_DONE)
      else $error("Write with a bad length was not refused.");
   ptr_step_a: assert property ((s.st == ST_WDATA && rx_valid && !bus_reset &&
                                 s.cmd == CMD_IPB_WRITE)
                                |=> s.ptr == IPB_AW'($past(s.ptr) + 1'b1))
      else $error("Write pointer did not advance by one byte.");
   free_bound_a: assert property (xin_free <= XIN_FREE_RST)
      else $error("Free input count above section size.");

   cover property (s.st == ST_CRC_HI && tx_req && s.cmd == CMD_IPB_WRITE);
   cover property (s.st == ST_CRC_HI && tx_req && s.cmd == CMD_IPB_READ && !ipb_processed);
   cover property (xin_notify);
   cover property (s.st == ST_ANSWER && tx_req && !s.conf_ok);
   cover property (s.st == ST_CMD && rx_valid && s_next.st == ST_DONE);

endmodule : cbcp_cmd_port

// >>> cbcp_master_model.sv
// Byte-level model of the single-wire bus master facing the command port.
// Assumes the bench calls one task at a time and that slot timing is done below.
`timescale 1ns/1ps
module cbcp_master_model (
   // Clock.
   input wire logic core_clk,
   // Link events.
   output logic rom_done,
   output logic bus_reset,
   // Bytes to the port.
   output logic rx_valid,
   output logic [7:0] rx_data,
   // Read slots.
   output logic tx_req,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_msb_first
);
   int gap = 0;

   initial begin
      rom_done = 1'b0;
      bus_reset = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_req = 1'b0;
   end

   // A slow master leaves idle cycles before each byte.
   task automatic pause();
      repeat (gap) @(posedge core_clk);
   endtask : pause

   task automatic pulse_rom();
      @(posedge core_clk);
      rom_done <= 1'b1;
      @(posedge core_clk);
      rom_done <= 1'b0;
   endtask : pulse_rom

   task automatic pulse_reset();
      @(posedge core_clk);
      bus_reset <= 1'b1;
      @(posedge core_clk);
      bus_reset <= 1'b0;
   endtask : pulse_reset

   task automatic send(input logic [7:0] b);
      pause();
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      // Once released the byte lines must not keep the old value.
      rx_data <= ~b;
   endtask : send

   // The answer stands for one cycle only, so it is taken right after the edge.
   task automatic fetch(output logic v, output logic [7:0] d, output logic m);
      pause();
      @(posedge core_clk);
      tx_req <= 1'b1;
      @(posedge core_clk);
      tx_req <= 1'b0;
      #1;
      v = tx_valid;
      d = tx_data;
      m = tx_msb_first;
   endtask : fetch
endmodule : cbcp_master_model

// >>> tb.sv
// Self-checking bench for the coprocessor buffer command port.
// Assumes the master model drives the link side and the bench plays the micro.
`timescale 1ns/1ps
module tb;
   import cbcp_pkg::*;
   logic core_clk, reset, rom_done, bus_reset, rx_valid, tx_req, tx_valid;
   logic tx_msb_first, ipb_processed, xin_take, xin_notify;
   logic [7:0] rx_data, tx_data;
   logic [3:0] xout_count, xin_free, xout_valid;
   logic [63:0] xin_data;
   logic [15:0] crc;
   logic [7:0] pat [0:127];
   int bad_count = 0;
   int n_compared = 0;
   int notes = 0;

   cbcp_cmd_port i_cbcp_cmd_port (.core_clk(core_clk), .reset(reset), .rom_done(rom_done),
      .bus_reset(bus_reset), .rx_valid(rx_valid), .rx_data(rx_data), .tx_req(tx_req),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_msb_first(tx_msb_first),
      .ipb_processed(ipb_processed), .xin_take(xin_take), .xout_count(xout_count),
      .xin_data(xin_data), .xin_free(xin_free), .xout_valid(xout_valid),
      .xin_notify(xin_notify));
   cbcp_master_model i_cbcp_master_model (.core_clk(core_clk), .rom_done(rom_done),
      .bus_reset(bus_reset), .rx_valid(rx_valid), .rx_data(rx_data), .tx_req(tx_req),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_msb_first(tx_msb_first));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (xin_notify === 1'b1) begin
         notes++;
      end
   end

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // Reflected polynomial, zero seed, one wire bit at a time from bit 0.
   function automatic void crc_add(input logic [7:0] b);
      crc = crc ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         crc = crc[0] ? ((crc >> 1) ^ 16'hA001) : (crc >> 1);
      end
   endfunction : crc_add

   task automatic put(input logic [7:0] b);
      i_cbcp_master_model.send(b);
      crc_add(b);
   endtask : put

   task automatic start(input logic [7:0] cmd, input logic [7:0] len);
      i_cbcp_master_model.pulse_reset();
      i_cbcp_master_model.pulse_rom();
      crc = 16'h0000;
      put(cmd);
      put(len);
   endtask : start

   task automatic get(input string what, input logic [7:0] exp, input logic msb);
      logic v;
      logic [7:0] d;
      logic [7:0] r;
      logic m;
      i_cbcp_master_model.fetch(v, d, m);
      check(what, {63'h0, v}, 64'h1);
      check(what, {63'h0, m}, {63'h0, msb});
      check(what, {56'h0, d}, {56'h0, exp});
      // A byte sent high bit first reaches the wire checksum bit-reversed.
      for (int k = 0; k < 8; k++) begin
         r[k] = msb ? exp[7 - k] : exp[k];
      end
      crc_add(r);
   endtask : get

   task automatic get_crc(input string what);
      logic [15:0] c;
      c = ~crc;
      get(what, c[7:0], 1'b0);
      get(what, c[15:8], 1'b0);
   endtask : get_crc

   task automatic quiet(input string what);
      logic v;
      logic [7:0] d;
      logic m;
      i_cbcp_master_model.fetch(v, d, m);
      check(what, {63'h0, v}, 64'h0);
   endtask : quiet

   task automatic rd(input int len, input int first, input int step, input logic msb);
      @(posedge core_clk);
      ipb_processed <= ~msb;
      start(CMD_IPB_READ, 8'(len));
      for (int i = 0; i < len; i++) begin
         get("read data", pat[(first + step * i + 256) % 128], msb);
      end
      get_crc("read crc");
   endtask : rd

   task automatic xw(input logic [7:0] len, input logic [7:0] hi, input logic [7:0] ans,
                     input int dn);
      int n0;
      n0 = notes;
      start(CMD_XIN_WRITE, len);
      for (int i = 0; i < int'(len); i++) begin
         put(8'(17 * (i + 1)));
      end
      get_crc("xin crc");
      put(CONF_XIN_WRITE[7:0]);
      put(hi);
      get("xin answer", ans, 1'b0);
      check("xin notify", 64'(notes - n0), 64'(dn));
   endtask : xw

   task automatic t_reset_vals();
      check("tx_valid", {63'h0, tx_valid}, 64'h0);
      check("xin_free", {60'h0, xin_free}, 64'h8);
      check("xin_notify", {63'h0, xin_notify}, 64'h0);
      check("xout_valid", {60'h0, xout_valid}, 64'h0);
      check("xin_data", xin_data, 64'h0);
   endtask : t_reset_vals

   task automatic t_write_full();
      start(CMD_IPB_WRITE, 8'h80);
      for (int i = 0; i < 128; i++) begin
         pat[i] = 8'(i);
         put(pat[i]);
      end
      get_crc("write crc");
      quiet("after crc");
   endtask : t_write_full

   // Three new bytes over a full buffer, then a full LIFO read and the restore.
   task automatic t_partial_and_restore();
      start(CMD_IPB_WRITE, 8'h03);
      pat[0] = 8'hA1;
      pat[1] = 8'hB2;
      pat[2] = 8'hC3;
      for (int i = 0; i < 3; i++) begin
         put(pat[i]);
      end
      get_crc("short write crc");
      rd(128, 2, -1, 1'b1);
      rd(3, 2, -1, 1'b1);
      rd(125, 127, -1, 1'b1);
      rd(3, 2, -1, 1'b1);
      rd(2, 0, 1, 1'b0);
   endtask : t_partial_and_restore

   task automatic t_exchange();
      i_cbcp_master_model.gap = 2;
      xw(8'h03, 8'h9D, ANS_ACCEPT, 1);
      check("xin_free", {60'h0, xin_free}, 64'h5);
      check("xin_data", {40'h0, xin_data[23:0]}, 64'h332211);
      xw(8'h06, 8'h9D, ANS_REJECT, 0);
      check("xin_free", {60'h0, xin_free}, 64'h5);
      @(posedge core_clk);
      xin_take <= 1'b1;
      xout_count <= 4'h6;
      @(posedge core_clk);
      xin_take <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check("xin_free", {60'h0, xin_free}, 64'h8);
      check("xout_valid", {60'h0, xout_valid}, 64'h6);
      xw(8'h01, 8'h00, ANS_REJECT, 0);
      check("xin_free", {60'h0, xin_free}, 64'h8);
      xw(8'h06, 8'h9D, ANS_ACCEPT, 1);
      check("xin_free", {60'h0, xin_free}, 64'h2);
      check("xin_data", {16'h0, xin_data[47:0]}, 64'h665544332211);
      i_cbcp_master_model.gap = 0;
   endtask : t_exchange

   task automatic t_abort();
      start(CMD_IPB_WRITE, 8'h04);
      put(8'h5A);
      i_cbcp_master_model.pulse_reset();
      i_cbcp_master_model.send(CMD_IPB_WRITE);
      i_cbcp_master_model.send(8'h01);
      i_cbcp_master_model.send(8'h5A);
      quiet("no addressing");
      start(CMD_IPB_WRITE, 8'h00);
      put(8'h5A);
      quiet("zero length");
      start(8'h55, 8'h01);
      quiet("unknown command");
      start(CMD_IPB_READ, 8'h81);
      quiet("read too long");
      start(CMD_IPB_READ, 8'h00);
      get_crc("empty read crc");
      start(CMD_IPB_WRITE, 8'h01);
      put(8'h5A);
      get_crc("after abort");
   endtask : t_abort

   task automatic close_out();
      if (bad_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   initial begin
      reset = 1'b1;
      ipb_processed = 1'b0;
      xin_take = 1'b0;
      xout_count = 4'h0;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      #1;
      t_reset_vals();
      t_write_full();
      t_partial_and_restore();
      t_exchange();
      t_abort();
      close_out();
   end

   // Whole run needs about 1200 cycles; this leaves ample margin.
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      close_out();
   end
endmodule : tb
